/* hdl/msd_params.svh */
// Offsets, field positions, reset values and timing counts of the decode block
`ifndef MSD_PARAMS_SVH
`define MSD_PARAMS_SVH

// Configuration register space offsets (low address byte)
`define MSD_OFF_PWR_ZERO   8'hB0
`define MSD_OFF_PWR_TWO    8'hB4
`define MSD_OFF_VMAP       8'hC2
`define MSD_OFF_PAGE       8'hE0
`define MSD_OFF_ID0        8'hF0
`define MSD_OFF_ID1        8'hF1

// Reset values
`define MSD_PAGE_RESET     8'h00
`define MSD_VMAP_RESET     8'h0C
`define MSD_PWR_ZERO_RESET 8'h08
`define MSD_PWR_TWO_RESET  8'h00

// Space-mapping bits
`define MSD_MAP_SRAM_PRG   0
`define MSD_MAP_SEC_PRG    1
`define MSD_MAP_MAIN_PRG   2
`define MSD_MAP_SEC_DATA   3
`define MSD_MAP_MAIN_DATA  4

// Power management bits
`define MSD_TURBO_BIT      3
`define MSD_GATE_LSB       2
`define MSD_GATE_N         5

// Product-term layout of the decode array
`define MSD_KEY_W          24
`define MSD_PT_N           70
`define MSD_PT_MAIN        0
`define MSD_PT_SEC         48
`define MSD_PT_SRAM        60
`define MSD_PT_CFG         63
`define MSD_PT_JTAG        64
`define MSD_PT_PIO         65
`define MSD_PT_ECS         67
`define MSD_PT_PER_SEL     3

// Input bus field positions
`define MSD_BUS_W          82
`define MSD_BUS_ADDR       0
`define MSD_BUS_CNTL       16
`define MSD_BUS_RST        19
`define MSD_BUS_PWRDN      20
`define MSD_BUS_PABC       21
`define MSD_BUS_PD         45
`define MSD_BUS_PF         49
`define MSD_BUS_PAGE       57
`define MSD_BUS_FBA        65
`define MSD_BUS_FBB        73
`define MSD_BUS_RDY        81

// Standby settle time
`define MSD_CLK_PERIOD_NS  10
`define MSD_STANDBY_NS     70
`define MSD_STANDBY_CYC    ((`MSD_STANDBY_NS + `MSD_CLK_PERIOD_NS - 1) / `MSD_CLK_PERIOD_NS)

`endif

/* hdl/msd_pkg.sv */
// Types shared by the memory space decode modules
package msd_pkg;

  typedef enum logic [1:0] {
    MSD_PWR_ACTIVE  = 2'b00,
    MSD_PWR_SETTLE  = 2'b01,
    MSD_PWR_STANDBY = 2'b11
  } msd_pwr_t;

endpackage : msd_pkg

/* hdl/msd_dec_if.sv */
// Carrier between the control block and the decode array
`timescale 1ns/1ns
interface msd_dec_if;
  logic [15:0] dec_addr;
  logic [7:0]  page;
  logic [15:0] main_hit;
  logic [3:0]  sec_hit;
  logic        sram_hit;
  logic        cfg_hit;
  logic        jtag_hit;
  logic [1:0]  pio_hit;
  logic [2:0]  ecs_hit;

  modport ctrl (output dec_addr, output page,
                input main_hit, input sec_hit, input sram_hit, input cfg_hit,
                input jtag_hit, input pio_hit, input ecs_hit);
  modport arr  (input dec_addr, input page,
                output main_hit, output sec_hit, output sram_hit, output cfg_hit,
                output jtag_hit, output pio_hit, output ecs_hit);
endinterface : msd_dec_if

/* hdl/msd_decode_array.sv */
// Programmed product-term decode array with select priority
`timescale 1ns/1ns
`include "msd_params.svh"
module msd_decode_array
  import msd_pkg::*;
#(
  parameter logic [`MSD_PT_N*`MSD_KEY_W-1:0] PT_MASK  = '0,
  parameter logic [`MSD_PT_N*`MSD_KEY_W-1:0] PT_MATCH = '0,
  parameter logic [`MSD_PT_N-1:0]            PT_EN    = '0
) (
  msd_dec_if.arr dec
);

  logic [`MSD_KEY_W-1:0] key;
  logic [`MSD_PT_N-1:0]  term;
  logic [15:0]           main_raw;
  logic [3:0]            sec_raw;
  logic                  high_any;

  function automatic logic term_hit(input logic [`MSD_KEY_W-1:0] k,
                                    input logic [`MSD_KEY_W-1:0] m,
                                    input logic [`MSD_KEY_W-1:0] v);
    term_hit = ((k ^ v) & m) == '0;
  endfunction : term_hit

  function automatic logic or3(input logic [`MSD_PT_N-1:0] t, input int base);
    or3 = t[base] | t[base+1] | t[base+2];
  endfunction : or3

  // Page bits widen every term's key
  assign key = {dec.page, dec.dec_addr};

  genvar g;
  generate
    for (g = 0; g < `MSD_PT_N; g++) begin : g_term
      assign term[g] = PT_EN[g] &&
        term_hit(key, PT_MASK[g*`MSD_KEY_W +: `MSD_KEY_W],
                 PT_MATCH[g*`MSD_KEY_W +: `MSD_KEY_W]);
    end
    for (g = 0; g < 16; g++) begin : g_main
      assign main_raw[g] = or3(term, `MSD_PT_MAIN + g*`MSD_PT_PER_SEL);
    end
    for (g = 0; g < 4; g++) begin : g_sec
      assign sec_raw[g] = or3(term, `MSD_PT_SEC + g*`MSD_PT_PER_SEL);
    end
    for (g = 0; g < 3; g++) begin : g_ecs
      assign dec.ecs_hit[g] = term[`MSD_PT_ECS + g];
    end
  endgenerate

  assign dec.sram_hit  = or3(term, `MSD_PT_SRAM);
  assign dec.cfg_hit   = term[`MSD_PT_CFG];
  assign dec.jtag_hit  = term[`MSD_PT_JTAG];
  assign dec.pio_hit   = term[`MSD_PT_PIO +: 2];

  // SRAM, register space and peripherals beat flash; secondary beats main
  assign high_any     = dec.sram_hit | dec.cfg_hit | (|dec.pio_hit);
  assign dec.sec_hit  = high_any ? 4'h0 : sec_raw;
  assign dec.main_hit = (high_any || (|sec_raw)) ? 16'h0000 : main_raw;

endmodule : msd_decode_array

/* hdl/msd_top.sv */
// Memory space decode: host register access, space routing, input bus, standby
`timescale 1ns/1ns
`include "msd_params.svh"
// Behaviour
// - Route program fetches and data reads to memories per space-mapping register.
// - Space-mapping register starts at configured value; host may rewrite it from the second clock after reset.
// - Space-mapping bits 2 and 4 both set: main flash answers both strobes.
// - Eight page bits feed flash sector and SRAM select terms.
// - Page register read and written by host at register space offset E0h.
// - Page bits also offered to the general logic array.
// - Two read-only memory ID registers report the memory configuration.
// - Programmed decode logic works right after power-up without loading.
// - Turbo bit 3 cleared: standby after inputs stable about 70ns.
// - Three control bits (2 to 4) gate host strobes off the logic input bus.
// - Input bus carries 82 signals in the documented groups.
// - Wide-address mode puts A19-A4 on the sixteen address inputs.
// - Decode gives main, four secondary sector and SRAM selects, three terms each.
// - Decode gives register space, test port and two peripheral selects.
// - Decode array produces external chip selects 0 to 2, one term each.
// - SRAM, I/O, peripheral beat flash; secondary beats main on overlap.
module msd_top
  import msd_pkg::*;
#(
  parameter logic [7:0]                      VMAP_INIT = `MSD_VMAP_RESET,
  // Arbitrary neutral identification values
  parameter logic [7:0]                      MEM_ID0   = 8'h00,
  parameter logic [7:0]                      MEM_ID1   = 8'h00,
  parameter logic [`MSD_PT_N*`MSD_KEY_W-1:0] PT_MASK   = {`MSD_PT_N{24'h00_FF00}},
  parameter logic [`MSD_PT_N*`MSD_KEY_W-1:0] PT_MATCH  = {`MSD_PT_N{24'h00_FF00}},
  parameter logic [`MSD_PT_N-1:0]            PT_EN     = 70'h0_0000_0000_0000_0000 |
                                                         (70'h1 << `MSD_PT_CFG),
  parameter int                              SETTLE_W  = 4
) (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  arst_n,
  // Host bus
  input  wire logic [19:0]           host_addr,
  input  wire logic [7:0]            host_data_in,
  input  wire logic                  host_write_strobe,
  input  wire logic                  host_control_line_one,
  input  wire logic                  program_fetch_strobe,
  input  wire logic                  wide_addr_mode,
  output logic      [7:0]            host_data_out,
  output logic                       host_data_oe,
  // Other input bus sources
  input  wire logic                  system_reset_in,
  input  wire logic                  power_down_input,
  input  wire logic [23:0]           port_abc_inputs,
  input  wire logic [3:0]            port_d_inputs,
  input  wire logic [7:0]            port_f_inputs,
  input  wire logic [7:0]            macrocell_group_a_feedback,
  input  wire logic [7:0]            macrocell_group_b_feedback,
  input  wire logic                  flash_ready,
  // Selects
  output logic      [15:0]           main_flash_sector_selects,
  output logic      [3:0]            secondary_flash_sector_selects,
  output logic                       sram_select,
  output logic                       config_register_space,
  output logic                       jtag_port_select,
  output logic      [1:0]            peripheral_selects,
  output logic      [2:0]            external_chip_selects,
  // Logic array side
  output logic      [7:0]            page_bits,
  output logic      [`MSD_BUS_W-1:0] pld_input_bus,
  output logic                       pld_standby
);

  msd_dec_if dec ();

  logic [7:0]            space_mapping_register;
  logic [7:0]            power_mgmt_register_zero;
  logic [7:0]            power_mgmt_register_two;
  logic [`MSD_BUS_W-1:0] next_bus;
  logic [2:0]            gated_cntl;
  logic                  data_cyc;
  logic                  reg_wr;
  logic                  reg_rd;
  logic                  main_ok;
  logic                  sec_ok;
  logic                  sram_ok;
  logic [7:0]            next_rdata;
  msd_pwr_t              pwr_state;
  msd_pwr_t              next_pwr;
  logic [SETTLE_W-1:0]   settle_cnt;
  logic                  map_loaded;

  // Decode array is fixed logic, live from the first clock
  msd_decode_array #(
    .PT_MASK  (PT_MASK),
    .PT_MATCH (PT_MATCH),
    .PT_EN    (PT_EN)
  ) u_array (
    .dec (dec)
  );

  assign dec.dec_addr = wide_addr_mode ? host_addr[19:4] : host_addr[15:0];
  assign dec.page     = page_bits;

  assign data_cyc = host_control_line_one | host_write_strobe;
  assign reg_wr   = dec.cfg_hit & host_write_strobe;
  assign reg_rd   = dec.cfg_hit & host_control_line_one;

  // Page register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      page_bits <= `MSD_PAGE_RESET;
    end else if (reg_wr && host_addr[7:0] == `MSD_OFF_PAGE) begin
      page_bits <= host_data_in;
    end
  end

  // Space mapping, rewritable from the second clock after reset
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      space_mapping_register <= `MSD_VMAP_RESET;
      map_loaded             <= 1'b0;
    end else if (!map_loaded) begin
      space_mapping_register <= VMAP_INIT;
      map_loaded             <= 1'b1;
    end else if (reg_wr && host_addr[7:0] == `MSD_OFF_VMAP) begin
      space_mapping_register <= host_data_in;
    end
  end
  // Power management registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      power_mgmt_register_zero <= `MSD_PWR_ZERO_RESET;
      power_mgmt_register_two  <= `MSD_PWR_TWO_RESET;
    end else if (reg_wr) begin
      if (host_addr[7:0] == `MSD_OFF_PWR_ZERO) begin
        power_mgmt_register_zero <= host_data_in;
      end
      if (host_addr[7:0] == `MSD_OFF_PWR_TWO) begin
        power_mgmt_register_two <= host_data_in;
      end
    end
  end

  // Register read mux; unmapped offsets read zero
  always_comb begin
    next_rdata = 8'h00;
    unique case (host_addr[7:0])
      `MSD_OFF_PAGE:     next_rdata = page_bits;
      `MSD_OFF_VMAP:     next_rdata = space_mapping_register;
      `MSD_OFF_PWR_ZERO: next_rdata = power_mgmt_register_zero;
      `MSD_OFF_PWR_TWO:  next_rdata = power_mgmt_register_two;
      `MSD_OFF_ID0:      next_rdata = MEM_ID0;
      `MSD_OFF_ID1:      next_rdata = MEM_ID1;
      default:           next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      host_data_out <= 8'h00;
      host_data_oe  <= 1'b0;
    end else begin
      host_data_out <= reg_rd ? next_rdata : 8'h00;
      host_data_oe  <= reg_rd;
    end
  end

  // Space routing per strobe
  assign main_ok = (program_fetch_strobe & space_mapping_register[`MSD_MAP_MAIN_PRG]) |
                   (data_cyc & space_mapping_register[`MSD_MAP_MAIN_DATA]);
  assign sec_ok  = (program_fetch_strobe & space_mapping_register[`MSD_MAP_SEC_PRG]) |
                   (data_cyc & space_mapping_register[`MSD_MAP_SEC_DATA]);
  assign sram_ok = (program_fetch_strobe & space_mapping_register[`MSD_MAP_SRAM_PRG]) |
                   data_cyc;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      main_flash_sector_selects      <= 16'h0000;
      secondary_flash_sector_selects <= 4'h0;
      sram_select                    <= 1'b0;
      config_register_space          <= 1'b0;
      jtag_port_select               <= 1'b0;
      peripheral_selects             <= 2'h0;
      external_chip_selects          <= 3'h0;
    end else begin
      main_flash_sector_selects      <= main_ok ? dec.main_hit : 16'h0000;
      secondary_flash_sector_selects <= sec_ok ? dec.sec_hit : 4'h0;
      sram_select                    <= sram_ok & dec.sram_hit;
      config_register_space          <= data_cyc & dec.cfg_hit;
      jtag_port_select               <= dec.jtag_hit;
      peripheral_selects             <= data_cyc ? dec.pio_hit : 2'h0;
      external_chip_selects          <= dec.ecs_hit;
    end
  end

  // Input bus; blocking a strobe saves toggling power in the arrays
  assign gated_cntl = {program_fetch_strobe, host_control_line_one, host_write_strobe} &
                      ~power_mgmt_register_two[`MSD_GATE_LSB +: 3];
  assign next_bus = {flash_ready, macrocell_group_b_feedback, macrocell_group_a_feedback,
                     page_bits, port_f_inputs, port_d_inputs, port_abc_inputs,
                     power_down_input, system_reset_in, gated_cntl,
                     dec.dec_addr};

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pld_input_bus <= '0;
    end else begin
      pld_input_bus <= next_bus;
    end
  end

  // Standby tracker; standby costs extra delay on the next change
  always_comb begin
    next_pwr = pwr_state;
    if (power_mgmt_register_zero[`MSD_TURBO_BIT] || next_bus != pld_input_bus) begin
      next_pwr = MSD_PWR_ACTIVE;
    end else begin
      unique case (pwr_state)
        MSD_PWR_ACTIVE:  next_pwr = MSD_PWR_SETTLE;
        MSD_PWR_SETTLE:  next_pwr = (settle_cnt == SETTLE_W'(`MSD_STANDBY_CYC - 1)) ?
                                    MSD_PWR_STANDBY : MSD_PWR_SETTLE;
        MSD_PWR_STANDBY: next_pwr = MSD_PWR_STANDBY;
        default:         next_pwr = MSD_PWR_ACTIVE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pwr_state   <= MSD_PWR_ACTIVE;
      settle_cnt  <= '0;
      pld_standby <= 1'b0;
    end else begin
      pwr_state   <= next_pwr;
      settle_cnt  <= (next_pwr == MSD_PWR_ACTIVE) ? '0 : settle_cnt + SETTLE_W'(1);
      pld_standby <= next_pwr == MSD_PWR_STANDBY;
    end
  end

  property p_page_write;
    @(posedge mclk) disable iff (!arst_n)
    (reg_wr && host_addr[7:0] == `MSD_OFF_PAGE) |=> page_bits == $past(host_data_in);
  endproperty
  a_page_write: assert property (p_page_write) else $error("page write lost");

  property p_page_read;
    @(posedge mclk) disable iff (!arst_n)
    (reg_rd && host_addr[7:0] == `MSD_OFF_PAGE) |=>
      host_data_oe && host_data_out == $past(page_bits);
  endproperty
  a_page_read: assert property (p_page_read) else $error("page read wrong");

  property p_id_read;
    @(posedge mclk) disable iff (!arst_n)
    (reg_rd && host_addr[7:0] == `MSD_OFF_ID1) |=> host_data_out == MEM_ID1;
  endproperty
  a_id_read: assert property (p_id_read) else $error("id read wrong");

  property p_main_space;
    @(posedge mclk) disable iff (!arst_n)
    (main_flash_sector_selects != 16'h0000) |->
      $past(program_fetch_strobe && space_mapping_register[`MSD_MAP_MAIN_PRG]) ||
      $past(data_cyc && space_mapping_register[`MSD_MAP_MAIN_DATA]);
  endproperty
  a_main_space: assert property (p_main_space) else $error("main flash off space");

  property p_combined;
    @(posedge mclk) disable iff (!arst_n)
    (space_mapping_register[`MSD_MAP_MAIN_PRG] && space_mapping_register[`MSD_MAP_MAIN_DATA]
     && (program_fetch_strobe || host_control_line_one) && dec.main_hit != 16'h0000)
      |=> main_flash_sector_selects == $past(dec.main_hit);
  endproperty
  a_combined: assert property (p_combined) else $error("combined space miss");

  property p_overlap;
    @(posedge mclk) disable iff (!arst_n)
    (sram_select || config_register_space || (|peripheral_selects) ||
     (|secondary_flash_sector_selects)) |-> main_flash_sector_selects == 16'h0000;
  endproperty
  a_overlap: assert property (p_overlap) else $error("priority broken");

  property p_gate;
    @(posedge mclk) disable iff (!arst_n)
    $past(power_mgmt_register_two[`MSD_GATE_LSB + 1]) |->
      !pld_input_bus[`MSD_BUS_CNTL + 1];
  endproperty
  a_gate: assert property (p_gate) else $error("blocked strobe leaked");

  property p_standby;
    @(posedge mclk) disable iff (!arst_n)
    $rose(pld_standby) |->
      !$past(power_mgmt_register_zero[`MSD_TURBO_BIT]) &&
      $past(pld_input_bus, 6) == pld_input_bus;
  endproperty
  a_standby: assert property (p_standby) else $error("early standby");

  property p_wide;
    @(posedge mclk) disable iff (!arst_n)
    $past(wide_addr_mode) |-> pld_input_bus[`MSD_BUS_ADDR +: 16] == $past(host_addr[19:4]);
  endproperty
  a_wide: assert property (p_wide) else $error("wide address wrong");

endmodule : msd_top

/* tb/msd_host_model.sv */
// Host microcontroller bus model driving the decode block
`timescale 1ns/1ns
module msd_host_model (
  // Clock
  input  wire logic        mclk,
  // Bus toward the block
  output logic      [19:0] host_addr,
  output logic      [7:0]  host_data_in,
  output logic             host_write_strobe,
  output logic             host_control_line_one,
  output logic             program_fetch_strobe,
  output logic             wide_addr_mode,
  input  wire logic [7:0]  host_data_out,
  input  wire logic        host_data_oe
);
  logic [7:0] last_data;

  initial begin
    host_addr             = 20'h0_0000;
    host_data_in          = 8'h00;
    last_data             = 8'h00;
    host_write_strobe     = 1'b0;
    host_control_line_one = 1'b0;
    program_fetch_strobe  = 1'b0;
    wide_addr_mode        = 1'b0;
  end

  // Any writable register, map included, may be rewritten mid-run
  task automatic reg_write(input logic [7:0] off, input logic [7:0] val);
    host_addr             = {12'h0FF, off};
    host_control_line_one = 1'b0;
    program_fetch_strobe  = 1'b0;
    wide_addr_mode        = 1'b0;
    host_data_in          = val;
    last_data             = val;
    host_write_strobe     = 1'b1;
    @(negedge mclk);
    host_write_strobe     = 1'b0;
    // Released data line must not keep showing the old byte
    host_data_in          = ~last_data;
    @(negedge mclk);
  endtask : reg_write

  task automatic reg_read(input logic [7:0] off, output logic [7:0] val, output logic oe);
    host_addr             = {12'h0FF, off};
    host_write_strobe     = 1'b0;
    program_fetch_strobe  = 1'b0;
    wide_addr_mode        = 1'b0;
    host_control_line_one = 1'b1;
    @(negedge mclk);
    val                   = host_data_out;
    oe                    = host_data_oe;
    host_control_line_one = 1'b0;
    @(negedge mclk);
  endtask : reg_read

  task automatic bus(input logic [19:0] a, input logic f, input logic r, input logic w);
    host_addr             = a;
    host_write_strobe     = 1'b0;
    program_fetch_strobe  = f;
    host_control_line_one = r;
    wide_addr_mode        = w;
  endtask : bus
endmodule : msd_host_model

/* tb/msd_top_tb.sv */
// Self-checking bench for the memory space decode block
`timescale 1ns/1ns
`include "msd_params.svh"
module msd_top_tb;
  import msd_pkg::*;
  // Arbitrary identification values
  localparam logic [7:0]  ID0 = 8'h3C;
  localparam logic [7:0]  ID1 = 8'hA5;
  localparam logic [69:0] PEN = 70'hB_9001_0000_0000_0001;

  function automatic logic [`MSD_PT_N*`MSD_KEY_W-1:0] pt(input bit sel);
    logic [`MSD_PT_N*`MSD_KEY_W-1:0] v;
    int                              ix [7];
    logic [23:0]                     mk [7];
    logic [23:0]                     mt [7];
    ix = '{0, 48, 60, 63, 64, 65, 67};
    mk = '{24'h00_F000, 24'h00_FF00, 24'hFF_FFF0, 24'h00_FF00, 24'h00_F000, 24'h00_F000,
           24'h00_F000};
    mt = '{24'h00_8000, 24'h00_8000, 24'h5A_8000, 24'h00_FF00, 24'h00_7000, 24'h00_6000,
           24'h00_5000};
    v = '0;
    for (int i = 0; i < 7; i++) v[ix[i]*24 +: 24] = sel ? mt[i] : mk[i];
    return v;
  endfunction : pt

  logic        mclk, arst_n, sys_rst, pwr_dn, rdy, oe, dout_oe, sram, cfg, jtag, stby;
  logic [19:0] addr;
  logic [7:0]  din, dout, pf, fba, fbb, page, v;
  logic        wr, rd_s, fetch, wide;
  logic [23:0] pabc;
  logic [3:0]  pd, sec;
  logic [15:0] main;
  logic [1:0]  pio;
  logic [2:0]  ecs;
  logic [81:0] pbus;
  logic [31:0] r;
  logic [31:0] rows [10];
  int          fail_count;
  int          comparisons;

  msd_top #(.MEM_ID0(ID0), .MEM_ID1(ID1), .PT_MASK(pt(0)), .PT_MATCH(pt(1)), .PT_EN(PEN)) uut (
    .mclk(mclk), .arst_n(arst_n), .host_addr(addr), .host_data_in(din),
    .host_write_strobe(wr), .host_control_line_one(rd_s), .program_fetch_strobe(fetch),
    .wide_addr_mode(wide), .host_data_out(dout), .host_data_oe(dout_oe),
    .system_reset_in(sys_rst), .power_down_input(pwr_dn), .port_abc_inputs(pabc),
    .port_d_inputs(pd), .port_f_inputs(pf), .macrocell_group_a_feedback(fba),
    .macrocell_group_b_feedback(fbb), .flash_ready(rdy), .main_flash_sector_selects(main),
    .secondary_flash_sector_selects(sec), .sram_select(sram), .config_register_space(cfg),
    .jtag_port_select(jtag), .peripheral_selects(pio), .external_chip_selects(ecs),
    .page_bits(page), .pld_input_bus(pbus), .pld_standby(stby));

  msd_host_model hst (
    .mclk(mclk), .host_addr(addr), .host_data_in(din), .host_write_strobe(wr),
    .host_control_line_one(rd_s), .program_fetch_strobe(fetch), .wide_addr_mode(wide),
    .host_data_out(dout), .host_data_oe(dout_oe));

  task automatic check(input logic [81:0] seen, input logic [81:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic rd(input logic [7:0] off, input logic [7:0] exp);
    hst.reg_read(off, v, oe);
    check(oe, 1'b1);
    check(v, exp);
  endtask : rd

  task automatic drive(input logic [19:0] a, input logic f, input logic rr, input logic w);
    hst.bus(a, f, rr, w);
    @(negedge mclk);
  endtask : drive

  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Whole run is about 120 cycles
  initial begin
    #50000;
    fail_count++;
    give_verdict();
  end

  initial begin
    fail_count = 0;
    comparisons = 0;
    arst_n = 1'b0;
    {sys_rst, pwr_dn, rdy} = 3'b101;
    {pabc, pd, pf, fba, fbb} = {24'hA5_C3F0, 4'h9, 8'h6B, 8'h1E, 8'hD2};
    rows = '{32'h0C81_0024, 32'h0C81_0010, 32'h1481_0014, 32'h1481_0024, 32'h0081_0020,
             32'h1C80_5012, 32'h0C80_5020, 32'h1C80_0511, 32'h0080_0520, 32'h0180_0521};
    repeat (20) @(negedge mclk);
    arst_n = 1'b1;
    repeat (2) @(negedge mclk);
    drive(20'h0_7123, 1'b0, 1'b0, 1'b0);
    check(jtag, 1'b1);
    check(page, 8'h00);
    rd(`MSD_OFF_PAGE, 8'h00);
    rd(`MSD_OFF_VMAP, 8'h0C);
    rd(`MSD_OFF_PWR_ZERO, 8'h08);
    rd(`MSD_OFF_PWR_TWO, 8'h00);
    $display("reset values done");
    hst.reg_write(`MSD_OFF_PAGE, 8'h5A);
    check(page, 8'h5A);
    check(pbus[64:57], 8'h5A);
    rd(`MSD_OFF_PAGE, 8'h5A);
    hst.reg_write(8'h37, 8'h5A);
    rd(8'h37, 8'h00);
    hst.reg_write(`MSD_OFF_ID0, 8'hFF);
    rd(`MSD_OFF_ID0, ID0);
    rd(`MSD_OFF_ID1, ID1);
    $display("registers done");
    for (int i = 0; i < 10; i++) begin
      r = rows[i];
      hst.reg_write(`MSD_OFF_VMAP, r[31:24]);
      drive({4'h0, r[23:8]}, r[5], r[4], 1'b0);
      check(main, {15'h0, r[2]});
      check(sec, {3'h0, r[1]});
      check(sram, r[0]);
    end
    hst.reg_write(`MSD_OFF_PAGE, 8'h00);
    hst.reg_write(`MSD_OFF_VMAP, 8'h1C);
    drive(20'h0_8005, 1'b0, 1'b1, 1'b0);
    check(sram, 1'b0);
    check(sec, 4'h1);
    $display("space mapping done");
    drive(20'h0_6000, 1'b0, 1'b1, 1'b0);
    check(pio, 2'b01);
    drive(20'h0_6000, 1'b0, 1'b0, 1'b0);
    check(pio, 2'b00);
    drive(20'h0_5000, 1'b0, 1'b0, 1'b0);
    check(ecs, 3'b001);
    drive(20'h0_FF00, 1'b0, 1'b1, 1'b0);
    check({cfg, main}, 17'h1_0000);
    $display("other selects done");
    drive(20'h0_1234, 1'b1, 1'b0, 1'b0);
    check(pbus[18:0], 19'h4_1234);
    check(pbus[81:19], {rdy, fbb, fba, 8'h00, pf, pd, pabc, pwr_dn, sys_rst});
    drive(20'hA_BCDE, 1'b0, 1'b0, 1'b1);
    check(pbus[15:0], 16'hABCD);
    hst.reg_write(`MSD_OFF_PWR_TWO, 8'h08);
    drive(20'h0_1234, 1'b0, 1'b1, 1'b0);
    check(pbus[18:16], 3'b000);
    hst.reg_write(`MSD_OFF_PWR_TWO, 8'h00);
    drive(20'h0_1234, 1'b0, 1'b1, 1'b0);
    check(pbus[18:16], 3'b010);
    $display("input bus done");
    hst.reg_write(`MSD_OFF_PWR_ZERO, 8'h00);
    repeat (4) @(negedge mclk);
    check(stby, 1'b0);
    repeat (4) @(negedge mclk);
    check(stby, 1'b1);
    pd = 4'h6;
    @(negedge mclk);
    check(stby, 1'b0);
    hst.reg_write(`MSD_OFF_PWR_ZERO, 8'h08);
    repeat (10) @(negedge mclk);
    check(stby, 1'b0);
    $display("standby done");
    hst.reg_write(`MSD_OFF_PAGE, 8'h33);
    arst_n = 1'b0;
    @(negedge mclk);
    check(page, 8'h00);
    arst_n = 1'b1;
    repeat (2) @(negedge mclk);
    rd(`MSD_OFF_VMAP, 8'h0C);
    $display("second reset done");
    give_verdict();
  end
endmodule : msd_top_tb
